// >>> hdl/mcu_reset_sequencer.sv
// reset sequencer top: source filtering, delay counter, flags, wishbone registers
//
// Register access over Wishbone and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module mcu_reset_sequencer #(
	parameter int POWER_ON_DELAY_CYC_P = rst_seq_pkg::POWER_ON_DELAY_CYC, // power-on delay
	parameter int MIN_DIP_CYC_P = rst_seq_pkg::MIN_DIP_DURATION_CYC // min dip duration
) (
	input wire logic clk_i, // 125 MHz
	input wire logic rst_i, // power-on reset, sync high
	input wire logic external_reset_pin_n_i, // async pin, low resets
	input wire logic supply_low_i, // async monitor: supply below threshold
	input wire logic undervoltage_reset_en_i, // configuration option
	input wire logic [1:0] undervoltage_threshold_i, // configuration option
	input wire logic wdt_timeout_i, // one-cycle pulse, same clock
	input wire logic sleep_i, // core is in idle or sleep
	input wire logic rc_osc_i, // clock source is an RC oscillator
	input wire logic short_startup_en_i, // configuration option
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // wishbone write
	input wire logic [3:0] wb_adr_i, // wishbone byte address
	input wire logic [3:0] wb_sel_i, // byte enables
	input wire logic [31:0] wb_dat_i, // write data
	output logic [31:0] wb_dat_o, // read data
	output logic wb_ack_o, // ack
	output logic core_reset_o, // full internal reset to core
	output logic pc_sp_clear_o, // one pulse: clear pc and sp only
	output logic periph_reset_o, // timers, prescaler, interrupts, port dirs
	output logic wdt_clear_o, // clears watchdog counter
	output logic [1:0] threshold_o, // threshold to supply monitor
	output logic timeout_flag_o, // time-out flag
	output logic powerdown_flag_o, // power-down flag
	output logic irq_o // level interrupt
);
	import rst_seq_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers: three stages, change accepted when stages two and three agree
	logic [2:0] pin_sync_reg;
	logic [2:0] low_sync_reg;
	logic pin_low_reg;
	logic supply_low_reg;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_sync_reg <= 3'h7;
			low_sync_reg <= 3'h0;
			pin_low_reg <= 1'b0;
			supply_low_reg <= 1'b0;
		end else begin
			pin_sync_reg <= {pin_sync_reg[1:0], external_reset_pin_n_i};
			low_sync_reg <= {low_sync_reg[1:0], supply_low_i};
			if (pin_sync_reg[1] == pin_sync_reg[2])
				pin_low_reg <= ~pin_sync_reg[2];
			if (low_sync_reg[1] == low_sync_reg[2])
				supply_low_reg <= low_sync_reg[2];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// dip filter: short dips are ignored
	logic [CNT_W-1:0] dip_cnt_reg;
	logic uv_event;
	assign uv_event = undervoltage_reset_en_i && supply_low_reg &&
		(dip_cnt_reg == CNT_W'(MIN_DIP_CYC_P));
	always_ff @(posedge clk_i) begin
		if (rst_i || !supply_low_reg || !undervoltage_reset_en_i)
			dip_cnt_reg <= '0;
		else if (dip_cnt_reg != CNT_W'(MIN_DIP_CYC_P))
			dip_cnt_reg <= dip_cnt_reg + 1'b1;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i)
			threshold_o <= 2'h0;
		else
			threshold_o <= undervoltage_threshold_i;
	end

	////////////////////////////////////////////////////////////////////////////////
	// sequencer
	seq_state_t state_reg;
	logic [CNT_W-1:0] delay_cnt_reg;
	logic [CNT_W-1:0] delay_total;
	logic full_event;
	logic wdt_run;
	logic wdt_sleep;
	assign wdt_run = wdt_timeout_i && !sleep_i;
	assign wdt_sleep = wdt_timeout_i && sleep_i;
	assign full_event = pin_low_reg || uv_event || wdt_run;
	assign delay_total = CNT_W'(POWER_ON_DELAY_CYC_P) + ((rc_osc_i && short_startup_en_i) ?
		CNT_W'(STARTUP_SHORT_CYC) : CNT_W'(STARTUP_LONG_CYC));
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= ST_HOLD;
			delay_cnt_reg <= '0;
		end else begin
			case (state_reg)
				ST_RUN: begin
					delay_cnt_reg <= '0;
					if (full_event)
						state_reg <= ST_HOLD;
					else if (wdt_sleep)
						state_reg <= ST_WAKE;
				end
				ST_HOLD: begin
					if (full_event)
						delay_cnt_reg <= '0;
					else if (delay_cnt_reg >= delay_total - 1'b1)
						state_reg <= ST_RUN;
					else
						delay_cnt_reg <= delay_cnt_reg + 1'b1;
				end
				ST_WAKE: begin
					state_reg <= full_event ? ST_HOLD : ST_RUN;
				end
				default: state_reg <= ST_HOLD;
			endcase
		end
	end

	// outputs registered from next state so they follow state without delay
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			core_reset_o <= 1'b1;
			periph_reset_o <= 1'b1;
			wdt_clear_o <= 1'b1;
			pc_sp_clear_o <= 1'b0;
		end else begin
			core_reset_o <= (state_reg == ST_HOLD && (full_event ||
				delay_cnt_reg < delay_total - 1'b1)) || (state_reg != ST_HOLD &&
				full_event);
			periph_reset_o <= (state_reg == ST_HOLD && (full_event ||
				delay_cnt_reg < delay_total - 1'b1)) || (state_reg != ST_HOLD &&
				full_event);
			// watchdog released with the core so it restarts counting at once
			wdt_clear_o <= (state_reg == ST_HOLD && (full_event ||
				delay_cnt_reg < delay_total - 1'b1)) || (state_reg != ST_HOLD &&
				full_event) || wdt_sleep;
			pc_sp_clear_o <= state_reg == ST_RUN && wdt_sleep && !full_event;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// reset cause flags
	logic bus_wr;
	logic [31:0] irq_mask_reg;
	logic pd_set_reg;
	assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timeout_flag_o <= 1'b0;
			powerdown_flag_o <= 1'b0;
			pd_set_reg <= 1'b0;
		end else begin
			pd_set_reg <= sleep_i;
			if (wdt_timeout_i) begin
				timeout_flag_o <= 1'b1;
				if (sleep_i)
					powerdown_flag_o <= 1'b1;
			end else if (sleep_i && !pd_set_reg) begin
				// sleep entry: power-down set, time-out cleared
				powerdown_flag_o <= 1'b1;
				timeout_flag_o <= 1'b0;
			end else if (bus_wr && wb_adr_i == CTRL_OFS && wb_dat_i[0]) begin
				// software clear, as a clear-watchdog instruction would do
				timeout_flag_o <= 1'b0;
				powerdown_flag_o <= 1'b0;
			end
			// pin and undervoltage resets deliberately touch neither flag
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// interrupts: bit0 full reset done, bit1 sleep wake, bit2 undervoltage seen
	logic [2:0] irq_stat_reg;
	logic [2:0] irq_ev;
	assign irq_ev = {uv_event, wdt_sleep, state_reg == ST_HOLD && !full_event &&
		delay_cnt_reg >= delay_total - 1'b1};
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat_reg <= IRQ_RST;
			irq_mask_reg <= '0;
			irq_o <= 1'b0;
		end else begin
			irq_stat_reg <= irq_ev | (irq_stat_reg &
				~((bus_wr && wb_adr_i == IRQ_STAT_OFS) ? wb_dat_i[2:0] : 3'h0));
			if (bus_wr && wb_adr_i == IRQ_MASK_OFS)
				irq_mask_reg <= {29'h0, wb_dat_i[2:0]};
			irq_o <= |(irq_stat_reg & irq_mask_reg[2:0]);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// wishbone slave, one wait state; unmapped reads return zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			case (wb_adr_i)
				STATUS_OFS: wb_dat_o <= {30'h0, powerdown_flag_o, timeout_flag_o};
				IRQ_STAT_OFS: wb_dat_o <= {29'h0, irq_stat_reg};
				IRQ_MASK_OFS: wb_dat_o <= irq_mask_reg;
				CTRL_OFS: wb_dat_o <= {29'h0, state_reg};
				default: wb_dat_o <= '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	chk_wake_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		pc_sp_clear_o |-> !core_reset_o) else $error("wake clear with full reset");
	chk_sleep_flags: assert property (@(posedge clk_i) disable iff (rst_i)
		wdt_sleep |=> timeout_flag_o && powerdown_flag_o) else $error("sleep flags");
	chk_run_to: assert property (@(posedge clk_i) disable iff (rst_i)
		wdt_run |=> timeout_flag_o) else $error("timeout flag not set");
	chk_run_reset: assert property (@(posedge clk_i) disable iff (rst_i)
		wdt_run |=> core_reset_o) else $error("watchdog no reset");
	chk_pin_reset: assert property (@(posedge clk_i) disable iff (rst_i)
		pin_low_reg |=> core_reset_o && periph_reset_o) else $error("pin no reset");
	chk_pd_keep: assert property (@(posedge clk_i) disable iff (rst_i)
		(wdt_run || pin_low_reg) && !sleep_i && !bus_wr |=> $stable(powerdown_flag_o))
		else $error("pd changed");
	chk_wdt_with_core: assert property (@(posedge clk_i) disable iff (rst_i)
		core_reset_o |-> wdt_clear_o) else $error("watchdog not cleared");
	chk_dip_filter: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(supply_low_reg) |-> !uv_event) else $error("dip not filtered");
	chk_uv_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		!undervoltage_reset_en_i |-> !uv_event) else $error("uv while off");
	chk_hold_min: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(core_reset_o) |-> $past(state_reg == ST_HOLD, 1)) else $error("early release");

	////////////////////////////////////////////////////////////////////////////////
	// checker helpers: cycles since the last full event, and the flag update causes
	logic [CNT_W-1:0] quiet_cnt_reg;
	logic sleep_entry;
	logic sw_clear;
	assign sleep_entry = sleep_i && !pd_set_reg;
	assign sw_clear = bus_wr && wb_adr_i == CTRL_OFS && wb_dat_i[0];
	// saturates so a long run never wraps into a false short hold
	always_ff @(posedge clk_i) begin
		if (rst_i || full_event)
			quiet_cnt_reg <= '0;
		else if (quiet_cnt_reg != '1)
			quiet_cnt_reg <= quiet_cnt_reg + 1'b1;
	end

	// release only after the whole delay has run without a new event
	chk_hold_span: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(core_reset_o) |-> quiet_cnt_reg >= delay_total - 1'b1)
		else $error("hold shorter than delay");

	// release lands in the run state
	chk_release_run: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(core_reset_o) |-> state_reg == ST_RUN)
		else $error("release without run state");

	// a new event during the hold restarts the count
	chk_restart_count: assert property (@(posedge clk_i) disable iff (rst_i)
		state_reg == ST_HOLD && full_event |=> delay_cnt_reg == '0)
		else $error("count not restarted");

	chk_hold_core: assert property (@(posedge clk_i) disable iff (rst_i)
		state_reg == ST_HOLD && full_event |=> core_reset_o)
		else $error("core released during event");

	// running with no event keeps the core out of reset
	chk_run_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
		state_reg == ST_RUN && !full_event |=> !core_reset_o)
		else $error("spurious core reset");

	chk_uv_full: assert property (@(posedge clk_i) disable iff (rst_i)
		uv_event |=> core_reset_o)
		else $error("undervoltage without reset");

	// peripherals always follow the core reset
	chk_periph_core: assert property (@(posedge clk_i) disable iff (rst_i)
		periph_reset_o == core_reset_o)
		else $error("periph reset differs");

	// sleep wake: one pulse, peripherals untouched, watchdog cleared
	chk_pcsp_single: assert property (@(posedge clk_i) disable iff (rst_i)
		pc_sp_clear_o |=> !pc_sp_clear_o)
		else $error("pc sp clear too long");

	chk_wake_periph: assert property (@(posedge clk_i) disable iff (rst_i)
		pc_sp_clear_o |-> !periph_reset_o)
		else $error("wake touched peripherals");

	chk_wake_wdt: assert property (@(posedge clk_i) disable iff (rst_i)
		pc_sp_clear_o |-> wdt_clear_o)
		else $error("wake left watchdog");

	// flag updates: sleep entry, software clear, and stickiness otherwise
	chk_sleep_entry: assert property (@(posedge clk_i) disable iff (rst_i)
		sleep_entry && !wdt_timeout_i |=> powerdown_flag_o && !timeout_flag_o)
		else $error("sleep entry flags");

	chk_sw_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		sw_clear && !wdt_timeout_i && !sleep_entry |=> !timeout_flag_o && !powerdown_flag_o)
		else $error("flags not cleared");

	chk_to_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
		timeout_flag_o && !sleep_entry && !sw_clear |=> timeout_flag_o)
		else $error("timeout flag lost");

	chk_pd_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
		powerdown_flag_o && !sw_clear |=> powerdown_flag_o)
		else $error("powerdown flag lost");

	chk_status_data: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_cyc_i && wb_stb_i && !wb_ack_o && wb_adr_i == STATUS_OFS |=>
		wb_dat_o == {30'h0, $past(powerdown_flag_o), $past(timeout_flag_o)})
		else $error("status read data");

	// threshold goes to the monitor one cycle late
	chk_thr_copy: assert property (@(posedge clk_i) disable iff (rst_i)
		1'b1 |=> threshold_o == $past(undervoltage_threshold_i))
		else $error("threshold not passed");

	// bus: every taken request answered next cycle, ack lasts one cycle
	chk_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered");

	chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");

	// interrupts: mask write, write-one-to-clear, level output
	chk_mask_write: assert property (@(posedge clk_i) disable iff (rst_i)
		bus_wr && wb_adr_i == IRQ_MASK_OFS |=> irq_mask_reg[2:0] == $past(wb_dat_i[2:0]))
		else $error("mask not written");

	chk_irq_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		bus_wr && wb_adr_i == IRQ_STAT_OFS && wb_dat_i[0] && !irq_ev[0] |=> !irq_stat_reg[0])
		else $error("release status not cleared");

	chk_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
		irq_o == $past(|(irq_stat_reg & irq_mask_reg[2:0])))
		else $error("interrupt level wrong");

	cov_restart: cover property (@(posedge clk_i) disable iff (rst_i)
		state_reg == ST_HOLD && full_event && delay_cnt_reg != '0);
	cov_run_wdt: cover property (@(posedge clk_i) disable iff (rst_i) wdt_run);
	cov_sleep_wdt: cover property (@(posedge clk_i) disable iff (rst_i) pc_sp_clear_o);
	cov_release: cover property (@(posedge clk_i) disable iff (rst_i) $fell(core_reset_o));
	cov_uv: cover property (@(posedge clk_i) disable iff (rst_i) uv_event);
endmodule // mcu_reset_sequencer
`default_nettype wire

// >>> hdl/rst_seq_pkg.sv
// constants and types shared by the reset sequencer
// Behaviour
// - undervoltage reset exists only when enabled; threshold comes from a configuration input.
// - undervoltage reset only after a dip longer than the minimum dip duration.
// - watchdog time-out while running acts like a pin reset plus time-out flag.
// - watchdog time-out in sleep clears only program counter and stack pointer; the code also pulses wdt_clear_o then.
// - internal reset held for power-on delay plus start-up timer period.
// - start-up timer is 128 cycles for crystals, optionally 2 for RC.
// - time-out and power-down flags kept for software to read the cause.
// - pin or undervoltage reset leaves both flags unchanged.
// - watchdog reset while running sets time-out flag, keeps power-down flag.
// - watchdog time-out in sleep sets both flags.
// - every reset disables interrupts and zeroes the program counter.
// - every reset clears the watchdog, which then counts again at once.
// - every reset switches the timer counter off.
// - every reset clears the timer prescaler.
// - every reset makes all port pins inputs.
// - every reset sets the stack pointer to the stack top.
// - pin held low resets; execution restarts at zero after release.
package rst_seq_pkg;
	localparam int CLK_HZ = 125000000;
	localparam int POWER_ON_DELAY_MS = 50;
	localparam int POWER_ON_DELAY_CYC = POWER_ON_DELAY_MS * (CLK_HZ / 1000);
	localparam int MIN_DIP_DURATION_US = 10;
	localparam int MIN_DIP_DURATION_CYC = MIN_DIP_DURATION_US * (CLK_HZ / 1000000);
	localparam int STARTUP_LONG_CYC = 128;
	localparam int STARTUP_SHORT_CYC = 2;
	localparam int CNT_W = 24;
	// wishbone byte offsets
	localparam logic [3:0] STATUS_OFS = 4'h0;
	localparam logic [3:0] IRQ_STAT_OFS = 4'h4;
	localparam logic [3:0] IRQ_MASK_OFS = 4'h8;
	localparam logic [3:0] CTRL_OFS = 4'hc;
	localparam logic [2:0] IRQ_RST = 3'h0;
	localparam logic [2:0] STAT_RST = 3'h0;
	typedef enum logic [2:0] {
		ST_RUN = 3'b001,
		ST_HOLD = 3'b010,
		ST_WAKE = 3'b100
	} seq_state_t;
endpackage

// >>> verification/mcu_reset_sequencer_tb.sv
// self-checking bench for the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module mcu_reset_sequencer_tb;
	import rst_seq_pkg::*;
	localparam int D = 20;
	localparam logic [31:0] Z = 32'h0000_0000;
	logic clk_i = 0, rst_i = 1, uv_en = 1, sleep = 0, rc = 0, short_en = 0;
	logic cyc = 0, stb = 0, we = 0;
	logic [3:0] adr = 4'h0;
	logic [31:0] wdat = Z, rdat, q;
	logic ack, core_rst, pcsp, prst, wclr, tof, powerdown_flag, irq, pin_n, sup_low, wdt;
	logic [1:0] thr;
	logic [1:0] thr_in = 2'h2;
	logic [3:0] sel = 4'hf;
	int err_count = 0, num_checks = 0, cr_cnt = 0, pcsp_cnt = 0;
	always #4 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cr_cnt += int'(core_rst === 1'b1);
		pcsp_cnt += int'(pcsp === 1'b1);
	end
	reset_sources_model reset_sources_model_i (.clk_i(clk_i), .pin_n_o(pin_n),
		.supply_low_o(sup_low), .wdt_timeout_o(wdt));
	mcu_reset_sequencer #(.POWER_ON_DELAY_CYC_P(D), .MIN_DIP_CYC_P(4)) mcu_reset_sequencer_i (
		.clk_i(clk_i), .rst_i(rst_i), .external_reset_pin_n_i(pin_n), .supply_low_i(sup_low),
		.undervoltage_reset_en_i(uv_en), .undervoltage_threshold_i(thr_in), .wdt_timeout_i(wdt),
		.sleep_i(sleep), .rc_osc_i(rc), .short_startup_en_i(short_en), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .core_reset_o(core_rst), .pc_sp_clear_o(pcsp),
		.periph_reset_o(prst), .wdt_clear_o(wclr), .threshold_o(thr), .timeout_flag_o(tof),
		.powerdown_flag_o(powerdown_flag), .irq_o(irq));
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// one classic cycle; holds the request until ack is sampled high
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) err_count++;
		q = rdat;
		cyc <= 1'b0; stb <= 1'b0;
		@(posedge clk_i);
	endtask
	// counts cycles until the core reset drops; sync stages widen the window
	task automatic hold_len(input int exp);
		int n;
		n = 0;
		// let the edge that took the event update the registered outputs first
		@(posedge clk_i);
		check("side resets", {30'h0, prst, wclr}, 32'h3);
		while (core_rst !== 1'b0 && n < 1000) begin
			@(posedge clk_i);
			n++;
		end
		check("hold length", 32'(n >= exp - 2 && n <= exp + 8), 32'h1);
	endtask
	task automatic quiet(input string name);
		repeat (12) @(posedge clk_i);
		check(name, cr_cnt, Z);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		hold_len(D + 128);
		check("flags power-on", {powerdown_flag, tof}, 2'b00);
		check("threshold", thr, 2'h2);
		sleep <= 1'b1;
		repeat (3) @(posedge clk_i);
		cr_cnt = 0; pcsp_cnt = 0;
		reset_sources_model_i.wdt_fire();
		repeat (4) @(posedge clk_i);
		check("pc sp pulse", pcsp_cnt, 32'h1);
		check("no full reset", cr_cnt, Z);
		check("flags sleep wdt", {powerdown_flag, tof}, 2'b11);
		sleep <= 1'b0;
		reset_sources_model_i.pin_low(5);
		repeat (10) @(posedge clk_i);
		reset_sources_model_i.pin_low(5);
		hold_len(D + 128);
		check("flags pin reset", {powerdown_flag, tof}, 2'b11);
		wb(1'b1, CTRL_OFS, 32'h0000_0001);
		wb(1'b0, STATUS_OFS, Z);
		check("status cleared", q, Z);
		reset_sources_model_i.wdt_fire();
		hold_len(D + 128);
		check("flags wdt run", {powerdown_flag, tof}, 2'b01);
		wb(1'b0, STATUS_OFS, Z);
		check("status read", q, 32'h1);
		sel <= 4'he;
		wb(1'b1, CTRL_OFS, 32'h0000_0001);
		sel <= 4'hf;
		wb(1'b0, STATUS_OFS, Z);
		check("clear without sel0", q, 32'h1);
		cr_cnt = 0;
		reset_sources_model_i.dip(2);
		quiet("short dip");
		reset_sources_model_i.dip(12);
		hold_len(D + 128);
		uv_en <= 1'b0;
		cr_cnt = 0;
		reset_sources_model_i.dip(12);
		quiet("dip disabled");
		thr_in <= 2'h1;
		repeat (2) @(posedge clk_i);
		check("threshold change", thr, 2'h1);
		rc <= 1'b1; short_en <= 1'b1;
		reset_sources_model_i.pin_low(5);
		hold_len(D + 2);
		wb(1'b1, IRQ_MASK_OFS, Z);
		wb(1'b0, IRQ_STAT_OFS, Z);
		check("irq pending", q & 32'h7, 32'h7);
		check("irq masked", irq, 1'b0);
		wb(1'b1, IRQ_MASK_OFS, 32'h0000_0001);
		repeat (2) @(posedge clk_i);
		check("irq raised", irq, 1'b1);
		wb(1'b1, IRQ_STAT_OFS, 32'h0000_0007);
		repeat (2) @(posedge clk_i);
		check("irq cleared", irq, 1'b0);
		wb(1'b0, IRQ_STAT_OFS, Z);
		check("stat cleared", q, Z);
		wb(1'b0, 4'h6, Z);
		check("unmapped read", q, Z);
		tally_and_finish();
	end
	// whole run takes under a thousand cycles
	initial begin
		repeat (20000) @(posedge clk_i);
		err_count++;
		tally_and_finish();
	end
endmodule // mcu_reset_sequencer_tb
`default_nettype wire

// >>> verification/reset_sources_model.sv
// model of supply monitor, external reset pin and watchdog time-out source
`timescale 1ns/1ps
`default_nettype none
module reset_sources_model (
	input wire logic clk_i, // system clock
	output logic pin_n_o, // reset pin, low resets
	output logic supply_low_o, // supply below threshold
	output logic wdt_timeout_o // one-cycle time-out pulse
);
	initial begin
		pin_n_o = 1'b1;
		supply_low_o = 1'b0;
		wdt_timeout_o = 1'b0;
	end
	// pin is pulled low for n cycles, then released to its pull-up level
	task automatic pin_low(input int n);
		pin_n_o <= 1'b0;
		repeat (n) @(posedge clk_i);
		pin_n_o <= 1'b1;
	endtask
	task automatic dip(input int n);
		supply_low_o <= 1'b1;
		repeat (n) @(posedge clk_i);
		supply_low_o <= 1'b0;
	endtask
	task automatic wdt_fire();
		wdt_timeout_o <= 1'b1;
		@(posedge clk_i);
		wdt_timeout_o <= 1'b0;
	endtask
endmodule // reset_sources_model
`default_nettype wire
